// >>> ebppm_pkg.sv
// package for the eight-bit port with peripheral pin multiplexing:
// register byte offsets, field positions, reset values and bus states.
// assumes a 32-bit ahb-lite slave with each register in one aligned word.
package ebppm_pkg;
   // register byte offsets, low byte of haddr
   localparam logic [7:0] OFS_PIN_LEVELS_C = 8'h00;
   localparam logic [7:0] OFS_OUTPUT_LATCH_C = 8'h04;
   localparam logic [7:0] OFS_DIRECTION_C = 8'h08;
   localparam logic [7:0] OFS_LATCH_G = 8'h0C;
   localparam logic [7:0] OFS_DIRECTION_G = 8'h10;
   localparam logic [7:0] OFS_CONFIG = 8'h14;
   localparam logic [7:0] OFS_DRIVE_STATUS = 8'h18;

   // reset values: every port pin an input, latches clear
   localparam logic [7:0] RST_DIRECTION_C = 8'hFF;
   localparam logic [7:0] RST_OUTPUT_LATCH_C = 8'h00;
   localparam logic [7:0] RST_LATCH_G = 8'h00;
   localparam logic [7:0] RST_DIRECTION_G = 8'h1F;
   localparam logic [7:0] RST_CONFIG = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // latch-g bit 5 is unimplemented and reads zero
   localparam logic [7:0] LATCH_G_MASK = 8'hDF;
   localparam logic [7:0] CONFIG_MASK = 8'h01;

   // open-drain selects inside direction-g and latch-g
   localparam int SPI_OD_BIT = 7;
   localparam int CC2_OD_BIT = 6;
   localparam int CC1_OD_BIT = 5;
   localparam int SER2_OD_BIT = 7;
   localparam int SER1_OD_BIT = 6;
   // second capture/compare pin select inside the config register
   localparam int C2SEL_BIT = 0;

   // pin positions of each shared function
   localparam int PIN_OSC_OUT = 0;
   localparam int PIN_OSC_IN = 1;
   localparam int PIN_CC2 = 1;
   localparam int PIN_CC1 = 2;
   localparam int PIN_SCK = 3;
   localparam int PIN_SDI = 4;
   localparam int PIN_SDO = 5;
   localparam int PIN_TX = 6;
   localparam int PIN_RX = 7;

   localparam int PORT_W = 8;
   localparam logic [23:0] RD_PAD = 24'h000000;

   // ahb slave phases, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WR = 4'b0010,
      ST_RD_WAIT = 4'b0100,
      ST_RD_OUT = 4'b1000
   } ebppm_bus_st_t;
endpackage

// >>> ebppm_port_mux.sv
// eight-bit bidirectional port with pin sharing for two capture/compare
// channels, the synchronous serial module and the serial transceiver.
// assumes pad inputs synchronous to hclk, peripheral controls from the
// same clock domain, and one ahb-lite master with this the only slave.
module ebppm_port_mux (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pads
   input wire logic [ebppm_pkg::PORT_W-1:0] pin_in,
   output logic [ebppm_pkg::PORT_W-1:0] pin_out,
   output logic [ebppm_pkg::PORT_W-1:0] pin_oe,
   output logic [ebppm_pkg::PORT_W-1:0] pin_analog_en,
   output logic [ebppm_pkg::PORT_W-1:0] pin_i2c_buffer_sel,
   // timer oscillator
   input wire logic timer_osc_enable,
   output logic timer_count_clock_in,
   // capture_compare_one
   input wire logic cc1_compare_active,
   input wire logic cc1_out,
   output logic cc1_capture_in,
   // capture_compare_two
   input wire logic cc2_compare_active,
   input wire logic cc2_out,
   output logic cc2_capture_in,
   output logic capture2_pin_select,
   // sync_serial_module
   input wire logic spi_enable,
   input wire logic spi_master,
   input wire logic spi_sck_out,
   input wire logic spi_sdo_out,
   input wire logic i2c_enable,
   input wire logic i2c_scl_out,
   input wire logic i2c_sda_out,
   input wire logic i2c_levels_sel,
   output logic spi_sck_in,
   output logic spi_sdi_in,
   output logic i2c_scl_in,
   output logic i2c_sda_in,
   // serial_transceiver
   input wire logic serial_enable,
   input wire logic serial_tx_drive,
   input wire logic serial_transmit_out,
   input wire logic serial_dt_drive,
   input wire logic serial_sync_data,
   output logic serial_receive_in,
   output logic serial_sync_clock,
   output logic serial_sync_data_in
);
   import ebppm_pkg::*;

   // software-visible state
   logic [7:0] direction_c_reg; // 1 = input, 0 = output
   logic [7:0] output_latch_c_reg; // port data when pin is an output
   logic [7:0] latch_g_reg; // carries serial open-drain selects
   logic [7:0] direction_g_reg; // carries spi and ccp open-drain selects
   logic [7:0] config_reg; // capture2 pin placement
   // sampled pad levels
   logic [7:0] pin_level_reg;
   // digital view of the pads, oscillator pins masked
   logic [7:0] pin_digital;
   // per-pin peripheral claim, drive, value and open-drain
   logic [7:0] claim;
   logic [7:0] fdrive;
   logic [7:0] fval;
   logic [7:0] fod;
   // resolved pad drive before the output flops
   logic [7:0] pin_out_next;
   logic [7:0] pin_oe_next;
   logic [7:0] pin_out_reg;
   logic [7:0] pin_oe_reg;
   // bus bookkeeping
   ebppm_bus_st_t bus_st_reg;
   ebppm_bus_st_t bus_st_next;
   logic [7:0] addr_reg; // latched address of the pending transfer
   logic [7:0] rd_mux; // read value for the latched address
   logic [31:0] hrdata_reg;
   logic take; // address phase accepted this cycle
   logic wr_en; // write data phase completes this cycle
   logic osc_on;
   logic c2sel;

   // shorthands for the oscillator mode and the channel-two pin select
   assign osc_on = timer_osc_enable;
   assign c2sel = config_reg[C2SEL_BIT];

   // bus handshake
   assign take = hsel && htrans[1] && hready;
   assign wr_en = (bus_st_reg == ST_WR);

   // pins 0 and 1 of the pin_levels_c read path read zero under the oscillator
   always_comb begin
      pin_digital = pin_level_reg;
      if (osc_on) begin
         pin_digital[PIN_OSC_OUT] = 1'b0;
         pin_digital[PIN_OSC_IN] = 1'b0;
      end
   end

   // sample the pads once; reads and peripheral inputs use this copy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_level_reg <= RST_ZERO;
      end else begin
         pin_level_reg <= pin_in;
      end
   end

   // peripheral claims, highest priority first on each pin
   always_comb begin
      claim = 8'h00;
      fdrive = 8'h00;
      fval = 8'h00;
      fod = 8'h00;
      // pin 0: oscillator owns it, digital output off
      if (osc_on) begin
         claim[PIN_OSC_OUT] = 1'b1;
      end
      // pin 1: oscillator wins over channel two
      if (osc_on) begin
         claim[PIN_OSC_IN] = 1'b1;
      end else if (c2sel && cc2_compare_active) begin
         claim[PIN_CC2] = 1'b1;
         fdrive[PIN_CC2] = 1'b1;
         fval[PIN_CC2] = cc2_out;
         fod[PIN_CC2] = direction_g_reg[CC2_OD_BIT];
      end
      // pin 2: channel one compare or pwm
      if (cc1_compare_active) begin
         claim[PIN_CC1] = 1'b1;
         fdrive[PIN_CC1] = 1'b1;
         fval[PIN_CC1] = cc1_out;
         fod[PIN_CC1] = direction_g_reg[CC1_OD_BIT];
      end
      // pins 3 and 4: i2c is always open-drain
      if (i2c_enable) begin
         claim[PIN_SCK] = 1'b1;
         fdrive[PIN_SCK] = 1'b1;
         fval[PIN_SCK] = i2c_scl_out;
         fod[PIN_SCK] = 1'b1;
         claim[PIN_SDI] = 1'b1;
         fdrive[PIN_SDI] = 1'b1;
         fval[PIN_SDI] = i2c_sda_out;
         fod[PIN_SDI] = 1'b1;
      end else if (spi_enable) begin
         // master drives the clock, slave forces the pin to input
         claim[PIN_SCK] = 1'b1;
         fdrive[PIN_SCK] = spi_master;
         fval[PIN_SCK] = spi_sck_out;
         fod[PIN_SCK] = direction_g_reg[SPI_OD_BIT];
         claim[PIN_SDI] = 1'b1;
      end
      // pin 5: spi data out
      if (spi_enable && !i2c_enable) begin
         claim[PIN_SDO] = 1'b1;
         fdrive[PIN_SDO] = 1'b1;
         fval[PIN_SDO] = spi_sdo_out;
         fod[PIN_SDO] = direction_g_reg[SPI_OD_BIT];
      end
      // pins 6 and 7: transceiver decides its own direction
      if (serial_enable) begin
         claim[PIN_TX] = 1'b1;
         fdrive[PIN_TX] = serial_tx_drive;
         fval[PIN_TX] = serial_transmit_out;
         fod[PIN_TX] = latch_g_reg[SER1_OD_BIT];
         claim[PIN_RX] = 1'b1;
         fdrive[PIN_RX] = serial_dt_drive;
         fval[PIN_RX] = serial_sync_data;
         fod[PIN_RX] = latch_g_reg[SER1_OD_BIT];
      end
   end

   // resolve each pad: claimed pins follow the function, others the port
   always_comb begin
      pin_out_next = 8'h00;
      pin_oe_next = 8'h00;
      for (int i = 0; i < PORT_W; i++) begin
         if (claim[i]) begin
            // open-drain only pulls low, the pad floats for a one
            if (fod[i]) begin
               pin_out_next[i] = 1'b0;
               pin_oe_next[i] = fdrive[i] && !fval[i];
            end else begin
               pin_out_next[i] = fval[i];
               pin_oe_next[i] = fdrive[i];
            end
         end else begin
            pin_out_next[i] = output_latch_c_reg[i];
            pin_oe_next[i] = !direction_c_reg[i];
         end
      end
   end

   // pad drive is registered so the pads never see a glitch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out_reg <= RST_ZERO;
         pin_oe_reg <= RST_ZERO;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;

   // analog hand-over and i2c buffer choice go to the pad cells
   always_comb begin
      pin_analog_en = 8'h00;
      pin_i2c_buffer_sel = 8'h00;
      pin_analog_en[PIN_OSC_OUT] = osc_on;
      pin_analog_en[PIN_OSC_IN] = osc_on;
      pin_i2c_buffer_sel[PIN_SCK] = i2c_enable && i2c_levels_sel;
      pin_i2c_buffer_sel[PIN_SDI] = i2c_enable && i2c_levels_sel;
   end

   // peripheral inputs, all from the sampled pad copy
   assign timer_count_clock_in = pin_digital[PIN_OSC_OUT];
   assign cc1_capture_in = pin_digital[PIN_CC1];
   // channel two sees nothing here when placed on its alternate pin
   assign cc2_capture_in = c2sel && pin_digital[PIN_CC2];
   assign capture2_pin_select = c2sel;
   assign spi_sck_in = pin_digital[PIN_SCK];
   assign spi_sdi_in = pin_digital[PIN_SDI];
   assign i2c_scl_in = pin_digital[PIN_SCK];
   assign i2c_sda_in = pin_digital[PIN_SDI];
   assign serial_receive_in = pin_digital[PIN_RX];
   assign serial_sync_clock = pin_digital[PIN_TX];
   assign serial_sync_data_in = pin_digital[PIN_RX];

   // bus phase sequencing; reads take one wait state so that the
   // returned word is a flop and a write just before it is visible
   always_comb begin
      bus_st_next = ST_IDLE;
      case (bus_st_reg)
         ST_IDLE, ST_WR, ST_RD_OUT: begin
            if (take && hwrite) begin
               bus_st_next = ST_WR;
            end else if (take) begin
               bus_st_next = ST_RD_WAIT;
            end else begin
               bus_st_next = ST_IDLE;
            end
         end
         ST_RD_WAIT: begin
            bus_st_next = ST_RD_OUT;
         end
         default: begin
            bus_st_next = ST_IDLE;
         end
      endcase
   end

   // phase register and latched address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_st_reg <= ST_IDLE;
         addr_reg <= RST_ZERO;
      end else begin
         bus_st_reg <= bus_st_next;
         if (take) begin
            addr_reg <= haddr[7:0];
         end
      end
   end

   // read multiplexer; unmapped addresses read zero
   always_comb begin
      case (addr_reg)
         OFS_PIN_LEVELS_C: rd_mux = pin_digital;
         OFS_OUTPUT_LATCH_C: rd_mux = output_latch_c_reg;
         OFS_DIRECTION_C: rd_mux = direction_c_reg;
         OFS_LATCH_G: rd_mux = latch_g_reg & LATCH_G_MASK;
         OFS_DIRECTION_G: rd_mux = direction_g_reg;
         OFS_CONFIG: rd_mux = config_reg & CONFIG_MASK;
         OFS_DRIVE_STATUS: rd_mux = pin_oe_reg;
         default: rd_mux = RST_ZERO;
      endcase
   end

   // read data captured during the wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h00000000;
      end else if (bus_st_reg == ST_RD_WAIT) begin
         hrdata_reg <= {RD_PAD, rd_mux};
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = (bus_st_reg != ST_RD_WAIT);
   assign hresp = 1'b0;

   // port-c direction; overrides never touch the stored bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         direction_c_reg <= RST_DIRECTION_C;
      end else if (wr_en && addr_reg == OFS_DIRECTION_C) begin
         direction_c_reg <= hwdata[7:0];
      end
   end

   // output latch, written at its own address or the level address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_latch_c_reg <= RST_OUTPUT_LATCH_C;
      end else if (wr_en && (addr_reg == OFS_OUTPUT_LATCH_C ||
                             addr_reg == OFS_PIN_LEVELS_C)) begin
         output_latch_c_reg <= hwdata[7:0];
      end
   end

   // port-g latch with serial open-drain selects
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_g_reg <= RST_LATCH_G;
      end else if (wr_en && addr_reg == OFS_LATCH_G) begin
         latch_g_reg <= hwdata[7:0] & LATCH_G_MASK;
      end
   end

   // port-g direction with spi and ccp open-drain selects
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         direction_g_reg <= RST_DIRECTION_G;
      end else if (wr_en && addr_reg == OFS_DIRECTION_G) begin
         direction_g_reg <= hwdata[7:0];
      end
   end

   // configuration; channel two defaults onto pin 1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         config_reg <= RST_CONFIG;
      end else if (wr_en && addr_reg == OFS_CONFIG) begin
         config_reg <= hwdata[7:0] & CONFIG_MASK;
      end
   end

   // hsize is accepted but unused: only whole-word transfers occur
   logic unused_size;
   assign unused_size = ^hsize;
endmodule

// >>> ebppm_port_mux_monitor.sv
// checker for the eight-bit port: bus timing and pin override relations.
// assumes one clock domain and that it is bound onto ebppm_port_mux.
module ebppm_port_mux_monitor (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // pads
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_analog_en,
   input wire logic [7:0] pin_i2c_buffer_sel,
   // peripherals
   input wire logic timer_osc_enable,
   input wire logic cc1_compare_active,
   input wire logic cc1_out,
   input wire logic cc2_capture_in,
   input wire logic capture2_pin_select,
   input wire logic spi_enable,
   input wire logic spi_master,
   input wire logic spi_sck_out,
   input wire logic i2c_enable,
   input wire logic i2c_scl_out,
   input wire logic i2c_sda_out,
   input wire logic i2c_levels_sel,
   input wire logic serial_enable,
   input wire logic serial_tx_drive,
   input wire logic serial_transmit_out,
   input wire logic serial_receive_in,
   input wire logic serial_sync_clock
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // a transfer is taken on this edge
   sequence s_take; hsel && htrans[1] && hready; endsequence
   // reads carry exactly one wait state
   sequence s_rd_wait; !hreadyout ##1 hreadyout; endsequence
   property p_rd; s_take ##0 !hwrite |=> s_rd_wait; endproperty
   a_rd: assert property (p_rd) else $error("read wait wrong");
   property p_wr; s_take ##0 hwrite |=> hreadyout && !hresp; endproperty
   a_wr: assert property (p_wr) else $error("write stalled");
   property p_rst; $rose(hresetn) |-> pin_oe == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("pin driven");
   property p_osc;
      timer_osc_enable |-> pin_analog_en[1:0] == 2'h3 ##1 pin_oe[1:0] == 2'h0;
   endproperty
   a_osc: assert property (p_osc) else $error("osc pins digital");
   // an open-drain pin may only release a high level
   property p_cc1;
      cc1_compare_active |=>
         (pin_oe[2] ? pin_out[2] == $past(cc1_out) : $past(cc1_out));
   endproperty
   a_cc1: assert property (p_cc1) else $error("pin2 wrong");
   property p_sck;
      spi_enable && !i2c_enable && spi_master |=>
         (pin_oe[3] ? pin_out[3] == $past(spi_sck_out) : $past(spi_sck_out));
   endproperty
   a_sck: assert property (p_sck) else $error("pin3 wrong");
   property p_sdi; spi_enable && !i2c_enable |=> !pin_oe[4]; endproperty
   a_sdi: assert property (p_sdi) else $error("pin4 driven");
   property p_i2c;
      i2c_enable |=> pin_out[4:3] == 2'h0 && pin_oe[3] == !$past(i2c_scl_out)
         && pin_oe[4] == !$past(i2c_sda_out);
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c pins wrong");
   property p_buf;
      pin_i2c_buffer_sel[4:3] == {2{i2c_enable && i2c_levels_sel}};
   endproperty
   a_buf: assert property (p_buf) else $error("buffer select");
   property p_tx;
      serial_enable && serial_tx_drive |=>
         (pin_oe[6] ? pin_out[6] == $past(serial_transmit_out)
                    : $past(serial_transmit_out));
   endproperty
   a_tx: assert property (p_tx) else $error("pin6 wrong");
   property p_rx;
      1'b1 |=> serial_receive_in == $past(pin_in[7])
         && serial_sync_clock == $past(pin_in[6]);
   endproperty
   a_rx: assert property (p_rx) else $error("serial inputs");
   property p_c2; !capture2_pin_select |-> !cc2_capture_in; endproperty
   a_c2: assert property (p_c2) else $error("pin1 capture");
endmodule
bind ebppm_port_mux ebppm_port_mux_monitor u_mon (.*);

// >>> ebppm_pad_model.sv
// pads and board: a driven pad shows the port, an idle one the board.
// assumes the testbench sets the board level of every pad.
module ebppm_pad_model (
   // port drivers
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // board level of undriven pads
   input wire logic [7:0] ext_level,
   // level at the pads
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // per-pin choice, so a released pad never keeps its last driven value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> testbench.sv
// self-checking bench for the eight-bit port over ahb-lite.
// assumes the package, the port and the pad model are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ebppm_pkg::*;
   // clock, reset, bus
   logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic hreadyout, hresp, hready;
   // pads
   logic [7:0] pin_in, pin_out, pin_oe, pin_analog_en, pin_i2c_buffer_sel;
   logic [7:0] ext_level = 8'h3C;
   // peripheral controls and inputs
   logic timer_osc_enable = '0, cc1_compare_active = '0, cc1_out = '0;
   logic cc2_compare_active = '0, cc2_out = '0, spi_enable = '0;
   logic spi_master = '0, spi_sck_out = '0, spi_sdo_out = '0;
   logic i2c_enable = '0, i2c_scl_out = '0, i2c_sda_out = '0;
   logic i2c_levels_sel = '0, serial_enable = '0, serial_tx_drive = '0;
   logic serial_transmit_out = '0, serial_dt_drive = '0;
   logic serial_sync_data = '0;
   logic timer_count_clock_in, cc1_capture_in, cc2_capture_in;
   logic capture2_pin_select, spi_sck_in, spi_sdi_in, i2c_scl_in;
   logic i2c_sda_in, serial_receive_in, serial_sync_clock;
   logic serial_sync_data_in;
   int fail_count = 0;
   int compares = 0;
   // registers in address order with their reset contents; 1C is unmapped
   logic [7:0] offs [7] = '{OFS_OUTPUT_LATCH_C, OFS_DIRECTION_C,
      OFS_LATCH_G, OFS_DIRECTION_G, OFS_CONFIG, OFS_DRIVE_STATUS, 8'h1C};
   logic [7:0] rstv [7] = '{RST_OUTPUT_LATCH_C, RST_DIRECTION_C,
      RST_LATCH_G, RST_DIRECTION_G, RST_CONFIG, RST_ZERO, RST_ZERO};
   // the only slave, so its ready is the bus ready
   assign hready = hreadyout;
   ebppm_port_mux DUT (.*);
   ebppm_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext_level), .pin_in(pin_in));
   initial begin
      forever #5 hclk = ~hclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single transfer; waits on hready in both phases
   task automatic xfer(input logic [7:0] a, input logic w,
         input logic [7:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(a, 1'b0, 8'h00, r);
      chk(r, {24'h0, e});
   endtask
   // pins lag a register or control change by one flop
   task automatic pins(input logic [7:0] oe, input logic [7:0] out);
      repeat (2) @(posedge hclk);
      #1;
      chk(pin_oe, oe);
      chk(pin_out, out);
   endtask
   task automatic finish_test;
      if (fail_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // generous: the sequence needs well under a thousand cycles
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk(pin_oe, 8'h00);
      chk(capture2_pin_select, 1'b1);
      for (int i = 0; i < 7; i++) begin
         rdc(offs[i], rstv[i]);
      end
      rdc(OFS_PIN_LEVELS_C, 8'h3C);
      wr(OFS_PIN_LEVELS_C, 8'hA5);
      rdc(OFS_OUTPUT_LATCH_C, 8'hA5);
      wr(OFS_DIRECTION_C, 8'h00);
      pins(8'hFF, 8'hA5);
      rdc(OFS_PIN_LEVELS_C, 8'hA5);
      // oscillator takes pins 0 and 1
      timer_osc_enable <= 1'b1;
      repeat (2) @(posedge hclk);
      #1;
      chk(pin_oe, 8'hFC);
      chk(pin_analog_en, 8'h03);
      chk(timer_count_clock_in, 1'b0);
      rdc(OFS_PIN_LEVELS_C, 8'hA4);
      timer_osc_enable <= 1'b0;
      wr(OFS_OUTPUT_LATCH_C, 8'h00);
      wr(OFS_DIRECTION_C, 8'hFF);
      cc1_compare_active <= 1'b1;
      cc1_out <= 1'b1;
      pins(8'h04, 8'h04);
      rdc(OFS_DIRECTION_C, 8'hFF);
      wr(OFS_DIRECTION_G, 8'h3F);
      rdc(OFS_DIRECTION_G, 8'h3F);
      pins(8'h00, 8'h00);
      @(posedge hclk);
      cc1_out <= 1'b0;
      pins(8'h04, 8'h00);
      @(posedge hclk);
      cc1_compare_active <= 1'b0;
      pins(8'h00, 8'h00);
      chk(cc1_capture_in, 1'b1);
      wr(OFS_DIRECTION_G, 8'h1F);
      cc2_compare_active <= 1'b1;
      cc2_out <= 1'b1;
      pins(8'h02, 8'h02);
      chk(cc2_capture_in, 1'b1);
      wr(OFS_CONFIG, 8'h00);
      pins(8'h00, 8'h00);
      chk(capture2_pin_select, 1'b0);
      chk(cc2_capture_in, 1'b0);
      rdc(OFS_CONFIG, 8'h00);
      wr(OFS_CONFIG, 8'h01);
      cc2_compare_active <= 1'b0;
      wr(OFS_DIRECTION_C, 8'h00);
      spi_enable <= 1'b1;
      spi_master <= 1'b1;
      spi_sck_out <= 1'b1;
      spi_sdo_out <= 1'b1;
      pins(8'hEF, 8'h28);
      chk(spi_sdi_in, 1'b1);
      @(posedge hclk);
      spi_master <= 1'b0;
      spi_sck_out <= 1'b0;
      ext_level <= 8'h08;
      pins(8'hE7, 8'h20);
      chk(spi_sck_in, 1'b1);
      chk(spi_sdi_in, 1'b0);
      @(posedge hclk);
      spi_enable <= 1'b0;
      i2c_enable <= 1'b1;
      i2c_levels_sel <= 1'b1;
      i2c_sda_out <= 1'b1;
      pins(8'hEF, 8'h00);
      chk(pin_i2c_buffer_sel, 8'h18);
      chk(i2c_scl_in, 1'b0);
      chk(i2c_sda_in, 1'b0);
      @(posedge hclk);
      i2c_enable <= 1'b0;
      serial_enable <= 1'b1;
      serial_tx_drive <= 1'b1;
      serial_transmit_out <= 1'b1;
      serial_dt_drive <= 1'b1;
      pins(8'hFF, 8'h40);
      wr(OFS_LATCH_G, 8'hFF);
      pins(8'hBF, 8'h00);
      rdc(OFS_LATCH_G, 8'hDF);
      serial_tx_drive <= 1'b0;
      serial_dt_drive <= 1'b0;
      ext_level <= 8'h80;
      pins(8'h3F, 8'h00);
      chk(serial_receive_in, 1'b1);
      chk(serial_sync_clock, 1'b0);
      chk(serial_sync_data_in, 1'b1);
      finish_test();
   end
endmodule
